// ### rtl/ubm_top.sv
// Unsigned byte multiplier of the CPU ALU with its product register.
// Assumes the decoder holds operands and strobes stable across a whole
// instruction cycle; the phase counter marks the four oscillator periods.
// Functional notes
// RL1: Both byte operands are unsigned; full unsigned product, no sign handling.
// RL2: Whole 16-bit product stored; bits 15:8 high byte, 7:0 low byte.
// RL3: A multiply leaves every arithmetic status flag unchanged.
// RL4: Product register fully updated within one instruction cycle.
// RL5: Operands are the working register and the addressed data-memory byte.
// RL6: Signed byte multiply: software subtracts operands from high byte.
// RL7: 16x16 unsigned: software sums four weighted byte products.
// RL8: 16x16 signed: software subtracts by high-byte bit 7.
// RL9: One instruction cycle spans four oscillator periods.
// RL10: Product bytes readable, held until next multiply or explicit write.
`include "ubm_defines.svh"
module ubm_top
   import ubm_pkg::*;
(
   // Clock and reset
   input  wire  logic               CLK,
   input  wire  logic               RST,
   // Operands from decode
   input  wire  logic               MULTIPLY_WORKING_BY_FILE,
   input  wire  ubm_pkg::ubm_byte_t WORKING_REGISTER,
   input  wire  ubm_pkg::ubm_byte_t FILE_OPERAND,
   // Explicit writes to the product bytes
   input  wire  logic               WR_HIGH,
   input  wire  logic               WR_LOW,
   input  wire  ubm_pkg::ubm_byte_t WR_DATA,
   // Status flags passed through
   input  wire  logic [4:0]         STATUS_IN,
   // Results
   output logic [1:0]               PHASE,
   output logic                     INSN_END,
   output ubm_pkg::ubm_byte_t       PRODUCT_HIGH_BYTE,
   output ubm_pkg::ubm_byte_t       PRODUCT_LOW_BYTE,
   output logic [4:0]               STATUS_OUT
);
   import ubm_pkg::*;

   // ****************************************
   // Instruction cycle phase
   // ****************************************
   ubm_phase_t phase_q;
   ubm_phase_t phase_d;
   logic       last_q;
   wire        at_q4 = (phase_q == UBM_Q4);

   always_comb begin
      unique case (phase_q)
         UBM_Q1:  phase_d = UBM_Q2;
         UBM_Q2:  phase_d = UBM_Q3;
         UBM_Q3:  phase_d = UBM_Q4;
         UBM_Q4:  phase_d = UBM_Q1; // RL9
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         phase_q <= UBM_Q1;
         last_q  <= 1'b0;
      end else begin
         phase_q <= phase_d;
         last_q  <= (phase_d == UBM_Q4);
      end
   end

   // ****************************************
   // Multiply datapath
   // ****************************************
   ubm_product_register_t product;

   ubm_array u_array (
      .a (WORKING_REGISTER), // RL5
      .b (FILE_OPERAND),
      .p (product)
   );

   // Commit at Q4 so the next instruction sees the full product
   wire do_mul = MULTIPLY_WORKING_BY_FILE & at_q4; // RL4
   // Multiply wins over a same-cycle byte write: both come from one opcode
   wire ld_hi  = do_mul | (WR_HIGH & at_q4);
   wire ld_lo  = do_mul | (WR_LOW & at_q4);
   wire ubm_byte_t hi_d = do_mul ? product[`UBM_HI_MSB:`UBM_HI_LSB] : WR_DATA;
   wire ubm_byte_t lo_d = do_mul ? product[`UBM_LO_MSB:`UBM_LO_LSB] : WR_DATA;

   ubm_byte_t hi_q;
   ubm_byte_t lo_q;
   logic [4:0] status_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         hi_q <= ubm_byte_t'(`UBM_PRODUCT_REGISTER_RESET >> `UBM_HI_LSB);
         lo_q <= ubm_byte_t'(`UBM_PRODUCT_REGISTER_RESET);
      end else begin
         if (ld_hi) begin
            hi_q <= hi_d; // RL2
         end
         if (ld_lo) begin
            lo_q <= lo_d; // RL10
         end
      end
   end

   // Flags pass untouched; the multiplier has no path into them
   always_ff @(posedge CLK) begin
      if (RST) begin
         status_q <= 5'h00;
      end else begin
         status_q <= STATUS_IN; // RL3
      end
   end

   assign PHASE             = phase_q;
   assign INSN_END          = last_q;
   assign PRODUCT_HIGH_BYTE = hi_q;
   assign PRODUCT_LOW_BYTE  = lo_q;
   assign STATUS_OUT        = status_q;

   // ****************************************
   // Checks
   // ****************************************
   mul_result_a: assert property (@(posedge CLK) disable iff (RST) // RL1
      do_mul |=> {hi_q, lo_q} ==
         16'($past(WORKING_REGISTER)) * 16'($past(FILE_OPERAND)))
      else $error("product register does not hold unsigned product");

   byte_split_a: assert property (@(posedge CLK) disable iff (RST) // RL2
      do_mul |=> hi_q == $past(product[15:8]) && lo_q == $past(product[7:0]))
      else $error("product bytes split wrongly");

   flags_kept_a: assert property (@(posedge CLK) disable iff (RST) // RL3
      1'b1 |=> STATUS_OUT == $past(STATUS_IN))
      else $error("status flags changed by multiplier");

   one_cycle_a: assert property (@(posedge CLK) disable iff (RST) // RL4
      phase_q == UBM_Q1 && MULTIPLY_WORKING_BY_FILE ##1
         MULTIPLY_WORKING_BY_FILE [*3] |=>
         {hi_q, lo_q} ==
            16'($past(WORKING_REGISTER)) * 16'($past(FILE_OPERAND)))
      else $error("multiply not complete within one instruction cycle");

   operand_src_a: assert property (@(posedge CLK) disable iff (RST) // RL5
      do_mul |-> product == 16'(WORKING_REGISTER) * 16'(FILE_OPERAND))
      else $error("operands not taken from working register and file");

   four_phase_a: assert property (@(posedge CLK) disable iff (RST) // RL9
      at_q4 |=> !at_q4 ##1 !at_q4 ##1 !at_q4 ##1 at_q4)
      else $error("instruction cycle is not four clocks");

   hold_product_register_a: assert property (@(posedge CLK) disable iff (RST) // RL10
      !ld_hi && !ld_lo |=> $stable(hi_q) && $stable(lo_q))
      else $error("product register changed without a load");

   write_byte_a: assert property (@(posedge CLK) disable iff (RST) // RL10
      WR_LOW && at_q4 && !do_mul |=> lo_q == $past(WR_DATA))
      else $error("explicit write to low byte lost");

   write_high_a: assert property (@(posedge CLK) disable iff (RST) // RL10
      WR_HIGH && at_q4 && !do_mul |=> hi_q == $past(WR_DATA))
      else $error("explicit write to high byte lost");

   // ****************************************
   // Reset, phase, priority and operand checks
   // ****************************************
   // The three reset checks run through reset on purpose: they watch what reset leaves
   phase_reset_a: assert property (@(posedge CLK) // RL9
      RST |=> phase_q == UBM_Q1 && !last_q)
      else $error("phase counter not cleared by reset");

   product_register_reset_a: assert property (@(posedge CLK) // RL10
      RST |=> hi_q == 8'h00 && lo_q == 8'h00)
      else $error("product register not cleared by reset");

   status_reset_a: assert property (@(posedge CLK) // RL3
      RST |=> STATUS_OUT == 5'h00)
      else $error("status copy not cleared by reset");

   insn_end_a: assert property (@(posedge CLK) disable iff (RST) // RL9
      INSN_END == at_q4)
      else $error("instruction end marker out of step with phase");

   phase_step_a: assert property (@(posedge CLK) disable iff (RST) // RL9
      PHASE != 2'h3 |=> PHASE == $past(PHASE) + 2'h1)
      else $error("phase did not advance by one");

   // A request seen early must wait for the last phase to commit
   no_early_load_a: assert property (@(posedge CLK) disable iff (RST) // RL4
      (MULTIPLY_WORKING_BY_FILE || WR_HIGH || WR_LOW) && !at_q4 |=>
         $stable(hi_q) && $stable(lo_q))
      else $error("product loaded outside the last phase");

   mul_priority_a: assert property (@(posedge CLK) disable iff (RST) // RL2
      do_mul && (WR_HIGH || WR_LOW) |=>
         hi_q == $past(product[15:8]) && lo_q == $past(product[7:0]))
      else $error("byte write beat a multiply");

   // Two operands of 128 or more give at least 16384 when unsigned
   unsigned_top_a: assert property (@(posedge CLK) disable iff (RST) // RL1
      do_mul && WORKING_REGISTER[7] && FILE_OPERAND[7] |=>
         hi_q >= 8'h40)
      else $error("high operand bits treated as signs");

   zero_operand_a: assert property (@(posedge CLK) disable iff (RST) // RL1
      do_mul && (WORKING_REGISTER == 8'h00 || FILE_OPERAND == 8'h00) |=>
         hi_q == 8'h00 && lo_q == 8'h00)
      else $error("product of a zero operand is not zero");
endmodule : ubm_top

// ### rtl/ubm_defines.svh
// Constants for the unsigned byte multiplier.
// Assumes inclusion by bare name from rtl/.
`ifndef UBM_DEFINES_SVH
`define UBM_DEFINES_SVH
`define UBM_OSC_PER_INSN  4
`define UBM_PRODUCT_REGISTER_RESET    16'h0000
`define UBM_HI_MSB        15
`define UBM_HI_LSB        8
`define UBM_LO_MSB        7
`define UBM_LO_LSB        0
`endif

// ### rtl/ubm_pkg.sv
// Types for the unsigned byte multiplier.
// Assumes nothing beyond a SystemVerilog compiler.
package ubm_pkg;
   typedef logic [7:0]  ubm_byte_t;
   typedef logic [15:0] ubm_product_register_t;
   typedef enum logic [1:0] {UBM_Q1, UBM_Q2, UBM_Q3, UBM_Q4} ubm_phase_t;
endpackage : ubm_pkg

// ### rtl/ubm_array.sv
// Combinational 8x8 unsigned array multiplier.
// Assumes operands held stable while the result is sampled.
module ubm_array
   import ubm_pkg::*;
(
   // Operands
   input  wire ubm_pkg::ubm_byte_t a,
   input  wire ubm_pkg::ubm_byte_t b,
   // Result
   output wire ubm_pkg::ubm_product_register_t p
);
   // ****************************************
   // Shift-add partial products
   // ****************************************
   function automatic ubm_product_register_t umul(input ubm_byte_t x, input ubm_byte_t y);
      ubm_product_register_t acc;
      acc = 16'h0000;
      for (int i = 0; i < 8; i++) begin
         if (y[i]) begin
            acc = ubm_product_register_t'(acc + (ubm_product_register_t'(x) << i)); // RL1
         end
      end
      return acc;
   endfunction : umul

   assign p = umul(a, b);
endmodule : ubm_array

// ### verif/ubm_cpu_model.sv
// Decoder model: holds one request per instruction cycle.
// Assumes the bench stages a command before the Q1 falling edge.
module ubm_cpu_model
   import ubm_pkg::*;
(
   // Clock and phase
   input  wire logic               clk,
   input  wire logic [1:0]         phase,
   // Staged command {multiply, write high, write low}
   input  wire logic [2:0]         cmd,
   input  wire ubm_pkg::ubm_byte_t a, b, d,
   // To the multiplier
   output logic                    mul, wr_hi, wr_lo,
   output ubm_pkg::ubm_byte_t      w, f, wd
);
   initial {mul, wr_hi, wr_lo, w, f, wd} = '0;
   // Idle operands are inverted so a stale value never looks valid
   always @(negedge clk) if (phase == 2'h0) begin
      {mul, wr_hi, wr_lo} <= cmd;
      w  <= cmd[2] ? a : ~a;
      f  <= cmd[2] ? b : ~b;
      wd <= d;
   end
endmodule : ubm_cpu_model

// ### verif/tb.sv
// Bench for the byte multiplier: table of products, then odd cases.
// Assumes ubm_top and ubm_cpu_model are compiled before it.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ubm_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, mul, wh, wl, ie;
   logic [1:0] ph;
   logic [2:0] cmd = '0;
   logic [4:0] sti = '0, sto;
   ubm_byte_t  a = '0, b = '0, d = '0, w, f, wd, p_hi, p_lo;
   int         fail_count = 0, tests_run = 0;
   // {a, b, product}
   logic [31:0] rows [6] = '{32'h0000_0000, 32'hffff_fe01, 32'h8002_0100,
      32'h1234_03a8, 32'ha55a_3a02, 32'h01ff_00ff};
   initial forever #5 clk = ~clk;
   ubm_cpu_model u_cpu (.clk(clk), .phase(ph), .cmd(cmd), .a(a), .b(b),
      .d(d), .mul(mul), .wr_hi(wh), .wr_lo(wl), .w(w), .f(f), .wd(wd));
   ubm_top u_dut (.CLK(clk), .RST(rst), .MULTIPLY_WORKING_BY_FILE(mul),
      .WORKING_REGISTER(w), .FILE_OPERAND(f), .WR_HIGH(wh), .WR_LOW(wl),
      .WR_DATA(wd), .STATUS_IN(sti), .PHASE(ph), .INSN_END(ie),
      .PRODUCT_HIGH_BYTE(p_hi), .PRODUCT_LOW_BYTE(p_lo), .STATUS_OUT(sto));
   task check(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task final_report;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   // One instruction, entered and left at a Q4 falling edge
   task insn(input logic [2:0] c, input ubm_byte_t x, y, z);
      cmd = c; a = x; b = y; d = z; sti = x[4:0] ^ y[4:0];
      @(negedge clk);
      // Keep the command up one edge past the Q1 falling edge at which the model latched it
      @(negedge clk);
      cmd = '0;
      repeat (2) @(negedge clk);
      check({15'h0, ie}, 16'h0001);
      @(negedge clk);
      check({11'h0, sto}, {11'h0, sti});
      repeat (3) @(negedge clk);
   endtask : insn
   // Signed byte product from the unsigned primitive
   task soft8(input ubm_byte_t x, y);
      ubm_byte_t hi;
      int        product_register;
      insn(3'b100, x, y, 8'h00);
      hi = p_hi;
      if (y[7]) hi = hi - x;
      if (x[7]) hi = hi - y;
      product_register = $signed(x) * $signed(y);
      check({hi, p_lo}, product_register[15:0]);
   endtask : soft8
   // Wide products summed from four byte products
   task soft16(input logic [15:0] x, y);
      logic [31:0] r;
      logic [31:0] e;
      r = '0;
      insn(3'b100, x[7:0], y[7:0], 8'h00);
      r = r + {16'h0, p_hi, p_lo};
      insn(3'b100, x[15:8], y[15:8], 8'h00);
      r = r + {p_hi, p_lo, 16'h0};
      insn(3'b100, x[7:0], y[15:8], 8'h00);
      r = r + {8'h0, p_hi, p_lo, 8'h0};
      insn(3'b100, x[15:8], y[7:0], 8'h00);
      r = r + {8'h0, p_hi, p_lo, 8'h0};
      e = x * y;
      check(r[31:16], e[31:16]);
      check(r[15:0], e[15:0]);
      if (y[15]) r[31:16] = r[31:16] - x;
      if (x[15]) r[31:16] = r[31:16] - y;
      e = $signed(x) * $signed(y);
      check(r[31:16], e[31:16]);
      check(r[15:0], e[15:0]);
   endtask : soft16
   initial begin
      #20us;
      fail_count++;
      final_report();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      check({p_hi, p_lo}, 16'h0000);
      while (ph !== 2'h3) @(negedge clk);
      foreach (rows[i]) begin
         insn(3'b100, rows[i][31:24], rows[i][23:16], 8'h00);
         check({p_hi, p_lo}, rows[i][15:0]);
      end
      $display("products done");
      insn(3'b000, 8'h00, 8'h00, 8'h77);
      check({p_hi, p_lo}, 16'h00ff);
      insn(3'b010, 8'h00, 8'h00, 8'h5c);
      check({p_hi, p_lo}, 16'h5cff);
      insn(3'b001, 8'h00, 8'h00, 8'h3d);
      check({p_hi, p_lo}, 16'h5c3d);
      $display("hold and writes done");
      // Multiply wins over a write in the same cycle
      insn(3'b111, 8'h0f, 8'h11, 8'haa);
      check({p_hi, p_lo}, 16'h00ff);
      soft8(8'hf3, 8'h25);
      soft8(8'h80, 8'hff);
      soft16(16'h8123, 16'hfe45);
      $display("software products done");
      rst = 1'b1;
      @(negedge clk);
      check({p_hi, p_lo, 6'h0, ph}, 24'h0);
      rst = 1'b0;
      $display("priority and reset done");
      final_report();
   end
endmodule : tb
